/* File: rtl/modem_rate_sync.sv */
// Modem rate generator, channel filter timing, offset tracking and sync
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RQ1] One rate setting for transmit and receive
// [RQ2] Rate is fxosc*(256+M)*2^E/2^28
// [RQ3] Software picks exponent from log2 formula
// [RQ4] Mantissa 256 rounds to exponent+1, zero
// [RQ5] Rates 1.2 to 500 kBaud, stepped
// [RQ6] Filter bandwidth fxosc/(8*(4+M)*2^E)
// [RQ7] Digital filtering, offset, signal level estimate
// [RQ8] Readable offset estimate; synth offset retunes
// [RQ9] Tracking range limited by range field
// [RQ10] Gate bit freezes tracking until carrier
// [RQ11] Gain before sync, second gain after
// [RQ12] No offset tracking for ASK or OOK
// [RQ13] Bit timing recovered, continuously realigned
// [RQ14] Transmit inserts 16 or 32 bit sync
// [RQ15] Continuous sync search sets byte boundaries
// [RQ16] Match at 15/16, 16/16 or 30/32
// [RQ17] Optional quality and carrier sense qualify
// [RQ18] Sync word from high and low bytes
// [RQ19] Sync mode 3 or 7 doubles word
// [RQ20] 28-bit accumulator emits symbol ticks
module modem_rate_sync (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Receive path from the front end
  input  wire logic        rx_bit_in,
  input  wire logic [7:0]  freq_error_in,
  input  wire logic [7:0]  amplitude_in,
  input  wire logic        carrier_sense,
  input  wire logic [7:0]  preamble_quality_indicator,
  input  wire logic        rx_restart,
  // Receive results
  output logic      [7:0]  rx_byte,
  output logic             rx_byte_valid,
  output logic             sync_found,
  output logic      [7:0]  rssi_level,
  output logic             filter_sample_tick,
  // Transmit path
  input  wire logic        tx_start,
  input  wire logic        tx_stop,
  input  wire logic        tx_data_in,
  output logic             tx_bit_req,
  output logic             tx_bit_out,
  output logic             tx_busy,
  // Synthesizer offset
  output logic      [7:0]  synth_offset_value
);
  import modem_pkg::*;

  // Register storage
  logic [7:0] rate_low_q, bw_rate_q, sync_setup_q, sync_hi_q, sync_lo_q;
  logic [7:0] ofs_cfg_q, synth_ofs_q, pqi_cfg_q;

  // Register fields
  wire [7:0]  rate_mantissa      = rate_low_q;
  wire [3:0]  rate_exponent      = bw_rate_q[RATE_E_LSB +: 4];
  wire [1:0]  filter_bw_exponent = bw_rate_q[BW_E_LSB +: 2];
  wire [1:0]  filter_bw_mantissa = bw_rate_q[BW_M_LSB +: 2];
  wire [2:0]  mod_format         = sync_setup_q[MOD_LSB +: 3];
  wire [1:0]  sync_thr           = sync_setup_q[1:0];
  wire        sync_need_cs       = sync_setup_q[SYNC_CS_BIT];
  wire        offset_freeze_until_carrier = ofs_cfg_q[OFS_GATE_BIT];
  wire [1:0]  offset_gain_before_sync = ofs_cfg_q[PRE_K_LSB +: 2];
  wire        offset_gain_after_sync  = ofs_cfg_q[POST_K_BIT];
  wire [1:0]  offset_track_range = ofs_cfg_q[LIMIT_LSB +: 2];
  wire        pqi_en             = pqi_cfg_q[PQI_EN_BIT];
  wire [6:0]  pqi_thr            = pqi_cfg_q[6:0];
  wire [15:0] sync_word          = {sync_hi_q, sync_lo_q}; // RQ18

  // APB decode; zero wait states, unmapped offsets answer with an error
  wire access  = psel & penable;
  wire hit_rw  = (paddr == ADDR_RATE_LOW) | (paddr == ADDR_BW_RATE) |
                 (paddr == ADDR_SYNC_SETUP) | (paddr == ADDR_SYNC_HI) |
                 (paddr == ADDR_SYNC_LO) | (paddr == ADDR_OFS_CFG) |
                 (paddr == ADDR_SYNTH_OFS) | (paddr == ADDR_PQI_CFG);
  wire hit_ro  = (paddr == ADDR_OFS_EST) | (paddr == ADDR_STATUS) |
                 (paddr == ADDR_RSSI);
  wire wr_en   = access & pwrite & hit_rw;
  assign pready  = 1'b1;
  assign pslverr = access & ~(hit_rw | hit_ro);

  // Configuration registers, written at the access phase only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rate_low_q   <= RST_RATE_LOW;
      bw_rate_q    <= RST_BW_RATE;
      sync_setup_q <= RST_SYNC_SETUP;
      sync_hi_q    <= RST_SYNC_HI;
      sync_lo_q    <= RST_SYNC_LO;
      ofs_cfg_q    <= RST_OFS_CFG;
      synth_ofs_q  <= RST_SYNTH_OFS;
      pqi_cfg_q    <= RST_PQI_CFG;
    end else if (wr_en) begin
      case (paddr)
        ADDR_RATE_LOW:   rate_low_q   <= pwdata[7:0];
        ADDR_BW_RATE:    bw_rate_q    <= pwdata[7:0];
        ADDR_SYNC_SETUP: sync_setup_q <= pwdata[7:0];
        ADDR_SYNC_HI:    sync_hi_q    <= pwdata[7:0];
        ADDR_SYNC_LO:    sync_lo_q    <= pwdata[7:0];
        ADDR_OFS_CFG:    ofs_cfg_q    <= pwdata[7:0];
        ADDR_SYNTH_OFS:  synth_ofs_q  <= pwdata[7:0];
        ADDR_PQI_CFG:    pqi_cfg_q    <= pwdata[7:0];
        default:         ;
      endcase
    end
  end

  // Writing the estimate here retunes the synthesizer directly
  assign synth_offset_value = synth_ofs_q; // RQ8

  // Read data mux
  logic signed [7:0] est_q;
  logic [7:0] rssi_q;
  logic       sync_found_q;
  tx_state_t  tx_state_q;
  wire [7:0] status = {5'h00, tx_state_q != TX_IDLE, carrier_sense,
                       sync_found_q};
  always_comb begin
    prdata = 32'h0000_0000;
    if (access & ~pwrite) begin
      case (paddr)
        ADDR_RATE_LOW:   prdata[7:0] = rate_low_q;
        ADDR_BW_RATE:    prdata[7:0] = bw_rate_q;
        ADDR_SYNC_SETUP: prdata[7:0] = sync_setup_q;
        ADDR_SYNC_HI:    prdata[7:0] = sync_hi_q;
        ADDR_SYNC_LO:    prdata[7:0] = sync_lo_q;
        ADDR_OFS_CFG:    prdata[7:0] = ofs_cfg_q;
        ADDR_SYNTH_OFS:  prdata[7:0] = synth_ofs_q;
        ADDR_PQI_CFG:    prdata[7:0] = pqi_cfg_q;
        ADDR_OFS_EST:    prdata[7:0] = est_q; // RQ8
        ADDR_STATUS:     prdata[7:0] = status;
        ADDR_RSSI:       prdata[7:0] = rssi_q;
        default:         prdata = 32'h0000_0000;
      endcase
    end
  end

  // Rate accumulator; same increment drives transmit and receive
  // Increment below 2^27 keeps the mid-symbol crossing detectable
  logic [27:0] acc_q;
  logic        rx_prev_q;
  wire  [23:0] rate_inc = 24'({15'h0000, RATE_BASE + {1'b0, rate_mantissa}}
                          << rate_exponent); // RQ2 RQ1 RQ5
  wire  [28:0] acc_sum  = {1'b0, acc_q} + {5'h00, rate_inc}; // RQ20
  wire         sym_tick = acc_sum[28]; // RQ20
  wire  [27:0] acc_base = acc_sum[27:0];
  wire         mid_tick = ~acc_q[27] & acc_base[27];
  wire         rx_edge  = rx_bit_in ^ rx_prev_q;
  wire  [27:0] to_wrap  = ~acc_base + 28'h0000001;
  // Edges are pulled toward the symbol boundary by 1/8 of the error
  wire  [27:0] acc_d = !rx_edge ? acc_base :
                       acc_base[27] ? acc_base + (to_wrap >> RESYNC_SH) :
                       acc_base - (acc_base >> RESYNC_SH); // RQ13

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q     <= 28'h0000000;
      rx_prev_q <= 1'b0;
    end else begin
      acc_q     <= acc_d;
      rx_prev_q <= rx_bit_in;
    end
  end

  // Channel filter output rate: 8*(4+M)*2^E crystal cycles per sample
  logic [8:0] filt_cnt_q;
  logic       filt_tick_q;
  // Shift kept 3 bits wide: exponent plus 3 reaches 6 and must not wrap
  wire  [2:0] filt_sh  = {1'b0, filter_bw_exponent} + 3'(BW_SCALE_SH);
  wire  [8:0] filt_div = 9'({6'h00, BW_BASE + {1'b0, filter_bw_mantissa}}
                         << filt_sh); // RQ6
  wire        filt_wrap = (filt_cnt_q == 9'h000);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      filt_cnt_q  <= 9'h000;
      filt_tick_q <= 1'b0;
    end else begin
      filt_cnt_q  <= filt_wrap ? filt_div - 9'h001 : filt_cnt_q - 9'h001;
      filt_tick_q <= filt_wrap; // RQ6
    end
  end
  assign filter_sample_tick = filt_tick_q;

  // Signal level estimate, leaky average per filter sample
  wire [8:0] rssi_diff = {1'b0, amplitude_in} - {1'b0, rssi_q};
  wire [8:0] rssi_step = {{RSSI_SH{rssi_diff[8]}}, rssi_diff[8:RSSI_SH]};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rssi_q <= 8'h00;
    end else if (filt_wrap) begin
      rssi_q <= rssi_q + rssi_step[7:0]; // RQ7
    end
  end
  assign rssi_level = rssi_q;

  // Offset tracking; loop gain switches once sync is found
  wire ask_ook  = (mod_format == MOD_ASK) | (mod_format == MOD_OOK);
  wire frozen   = offset_freeze_until_carrier & ~carrier_sense; // RQ10
  wire [2:0] k_sh = sync_found_q ?
         POST_K_BASE + {2'b00, offset_gain_after_sync} :
         PRE_K_BASE + {1'b0, offset_gain_before_sync}; // RQ11
  wire signed [9:0] est_diff = $signed({{2{freq_error_in[7]}}, freq_error_in})
                               - $signed({{2{est_q[7]}}, est_q});
  wire signed [9:0] est_raw  = $signed({{2{est_q[7]}}, est_q})
                               + (est_diff >>> k_sh);
  logic signed [9:0] est_lim;
  always_comb begin
    case (offset_track_range)
      2'h1:    est_lim = LIM_1;
      2'h2:    est_lim = LIM_2;
      2'h3:    est_lim = LIM_3;
      default: est_lim = 10'sd0;
    endcase
  end
  // Clamp keeps noise from walking the estimate past the range
  wire signed [9:0] est_clip = (est_raw > est_lim) ? est_lim :
                               (est_raw < -est_lim) ? -est_lim :
                               est_raw; // RQ9
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      est_q <= 8'sh00;
    end else if (ask_ook) begin
      est_q <= 8'sh00; // RQ12
    end else if (mid_tick & ~frozen) begin
      est_q <= est_clip[7:0]; // RQ7
    end
  end

  // Sync correlator over the last 32 recovered bits
  logic [31:0] rx_shift_q;
  logic        sampled_q;
  logic [2:0]  bit_cnt_q;
  logic [7:0]  rx_byte_q;
  logic        rx_valid_q;
  wire  [31:0] sync_pat = {sync_word, sync_word};
  wire  [31:0] mism;
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_corr
      assign mism[g] = rx_shift_q[g] ^ sync_pat[g];
    end
  endgenerate

  function automatic logic [5:0] ones32(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction : ones32

  wire [5:0] err16 = ones32({16'h0000, mism[15:0]});
  wire [5:0] err32 = ones32(mism);
  logic corr_ok;
  always_comb begin
    case (sync_thr)
      SYNC_15_16: corr_ok = (err16 <= ERR_15_16);
      SYNC_16_16: corr_ok = (err16 == 6'h00);
      SYNC_30_32: corr_ok = (err32 <= ERR_30_32); // RQ19
      default:    corr_ok = 1'b0;
    endcase
  end // RQ16
  wire qual_ok = (~pqi_en | (preamble_quality_indicator > {1'b0, pqi_thr}))
                 & (~sync_need_cs | carrier_sense); // RQ17
  wire no_sync = (sync_thr == SYNC_NONE);
  wire sync_hit = sampled_q & corr_ok & qual_ok & ~sync_found_q; // RQ15
  // A new hit wins over a restart in the same cycle
  wire sync_found_d = sync_hit | no_sync |
                      (sync_found_q & ~rx_restart); // RQ15

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_shift_q   <= 32'h0000_0000;
      sampled_q    <= 1'b0;
      sync_found_q <= 1'b0;
      bit_cnt_q    <= 3'h0;
      rx_byte_q    <= 8'h00;
      rx_valid_q   <= 1'b0;
    end else begin
      sampled_q    <= mid_tick;
      sync_found_q <= sync_found_d;
      rx_valid_q   <= 1'b0;
      if (mid_tick) begin
        rx_shift_q <= {rx_shift_q[30:0], rx_bit_in}; // RQ13
      end
      if (sync_hit) begin
        bit_cnt_q <= 3'h0; // RQ15
      end else if (sampled_q & sync_found_q) begin
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7) begin
          rx_byte_q  <= rx_shift_q[7:0];
          rx_valid_q <= 1'b1;
        end
      end
    end
  end
  assign rx_byte       = rx_byte_q;
  assign rx_byte_valid = rx_valid_q;
  assign sync_found    = sync_found_q;

  // Transmit sequencer: sync word first, then payload bits
  logic [31:0] tx_shift_q;
  logic [4:0]  tx_cnt_q;
  logic        tx_bit_q;
  logic        tx_req_q;
  wire         tx_double = (sync_thr == SYNC_30_32); // RQ19
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 32'h0000_0000;
      tx_cnt_q   <= 5'h00;
      tx_bit_q   <= 1'b0;
      tx_req_q   <= 1'b0;
    end else begin
      tx_req_q <= 1'b0;
      case (tx_state_q)
        TX_IDLE: begin
          if (tx_start) begin
            tx_state_q <= TX_SYNC;
            tx_shift_q <= tx_double ? sync_pat : {sync_word, 16'h0000};
            tx_cnt_q   <= tx_double ? 5'h1f : 5'h0f; // RQ14
          end
        end
        TX_SYNC: begin
          if (tx_stop) begin
            tx_state_q <= TX_IDLE;
          end else if (sym_tick) begin
            tx_bit_q   <= tx_shift_q[31]; // RQ14
            tx_shift_q <= {tx_shift_q[30:0], 1'b0};
            tx_cnt_q   <= tx_cnt_q - 5'h01;
            if (tx_cnt_q == 5'h00) begin
              tx_state_q <= TX_DATA;
            end
          end
        end
        TX_DATA: begin
          if (tx_stop) begin
            tx_state_q <= TX_IDLE;
          end else if (sym_tick) begin
            tx_bit_q <= tx_data_in; // RQ1
            tx_req_q <= 1'b1;
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end
  assign tx_bit_out = tx_bit_q;
  assign tx_bit_req = tx_req_q;
  assign tx_busy    = (tx_state_q != TX_IDLE);
endmodule : modem_rate_sync

`default_nettype wire

/* File: inc/modem_pkg.sv */
// Register map, field layout, reset values and modes of the modem core
package modem_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_RATE_LOW   = 8'h00;
  localparam logic [7:0] ADDR_BW_RATE    = 8'h04;
  localparam logic [7:0] ADDR_SYNC_SETUP = 8'h08;
  localparam logic [7:0] ADDR_SYNC_HI    = 8'h0c;
  localparam logic [7:0] ADDR_SYNC_LO    = 8'h10;
  localparam logic [7:0] ADDR_OFS_CFG    = 8'h14;
  localparam logic [7:0] ADDR_SYNTH_OFS  = 8'h18;
  localparam logic [7:0] ADDR_OFS_EST    = 8'h1c;
  localparam logic [7:0] ADDR_STATUS     = 8'h20;
  localparam logic [7:0] ADDR_PQI_CFG    = 8'h24;
  localparam logic [7:0] ADDR_RSSI       = 8'h28;
  // Reset values
  localparam logic [7:0] RST_RATE_LOW    = 8'h40;
  localparam logic [7:0] RST_BW_RATE     = 8'h88;
  localparam logic [7:0] RST_SYNC_SETUP  = 8'h02;
  localparam logic [7:0] RST_SYNC_HI     = 8'h5a;
  localparam logic [7:0] RST_SYNC_LO     = 8'hc3;
  localparam logic [7:0] RST_OFS_CFG     = 8'h36;
  localparam logic [7:0] RST_SYNTH_OFS   = 8'h00;
  localparam logic [7:0] RST_PQI_CFG     = 8'h00;
  // Field positions
  localparam int BW_E_LSB      = 6;
  localparam int BW_M_LSB      = 4;
  localparam int RATE_E_LSB    = 0;
  localparam int MOD_LSB       = 4;
  localparam int SYNC_CS_BIT   = 2;
  localparam int OFS_GATE_BIT  = 5;
  localparam int PRE_K_LSB     = 3;
  localparam int POST_K_BIT    = 2;
  localparam int LIMIT_LSB     = 0;
  localparam int PQI_EN_BIT    = 7;
  // Rate and filter arithmetic
  localparam logic [8:0] RATE_BASE    = 9'h100;
  localparam logic [2:0] BW_BASE      = 3'h4;
  localparam int         BW_SCALE_SH  = 3;
  localparam int         RESYNC_SH    = 3;
  localparam int         RSSI_SH      = 4;
  localparam logic [2:0] PRE_K_BASE   = 3'h1;
  localparam logic [2:0] POST_K_BASE  = 3'h3;
  // Modulation codes without offset compensation
  localparam logic [2:0] MOD_ASK = 3'h3;
  localparam logic [2:0] MOD_OOK = 3'h7;
  // Sync thresholds
  localparam logic [1:0] SYNC_NONE  = 2'h0;
  localparam logic [1:0] SYNC_15_16 = 2'h1;
  localparam logic [1:0] SYNC_16_16 = 2'h2;
  localparam logic [1:0] SYNC_30_32 = 2'h3;
  localparam logic [5:0] ERR_15_16  = 6'h01;
  localparam logic [5:0] ERR_30_32  = 6'h02;
  // Offset tracking limits, in 1/256 of the channel bandwidth
  localparam logic signed [9:0] LIM_1 = 10'sd32;
  localparam logic signed [9:0] LIM_2 = 10'sd64;
  localparam logic signed [9:0] LIM_3 = 10'sd127;
  // Transmit sequencer
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SYNC = 3'b010,
    TX_DATA = 3'b100
  } tx_state_t;
endpackage : modem_pkg

/* File: dv/radio_tx_model.sv */
// Remote transmitter model driving the demodulated bit stream
`timescale 1ns/1ps
`default_nettype none
module radio_tx_model #(
  parameter int PERIOD = 32
) (
  // Clock
  input  wire logic        clk,
  // Frame request, bits sent MSB first
  input  wire logic        go,
  input  wire logic [63:0] pattern,
  input  wire logic [6:0]  nbits,
  // Air side
  output logic             busy,
  output var logic         bit_out
);
  int          cnt_q  = 0;
  logic [63:0] sh_q   = '0;
  logic [6:0]  left_q = '0;
  logic        pend_q = 1'b0;
  // Line starts low so the receiver never sees an unknown level
  logic        line_q = 1'b0;

  assign busy    = pend_q || (left_q != 7'h0);
  assign bit_out = line_q;

  // Symbols on a fixed grid; between frames the line keeps toggling,
  // so a stale level never looks like a held bit
  always_ff @(posedge clk) begin
    cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    if (cnt_q == PERIOD - 1) begin
      if (left_q != 7'h0) begin
        line_q  <= sh_q[left_q-7'h1];
        left_q  <= left_q - 7'h1;
      end else if (pend_q) begin
        line_q  <= pattern[nbits-7'h1];
        sh_q    <= pattern;
        left_q  <= nbits - 7'h1;
        pend_q  <= 1'b0;
      end else begin
        line_q  <= ~line_q;
      end
    end
    if (go)
      pend_q <= 1'b1;
  end
endmodule : radio_tx_model
`default_nettype wire

/* File: dv/modem_rate_sync_asserts.sv */
// Port-level assertions for the modem rate and sync core
`timescale 1ns/1ps
`default_nettype none
module modem_rate_sync_asserts
  import modem_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Modem side
  input wire logic        rx_byte_valid,
  input wire logic        sync_found,
  input wire logic [7:0]  rssi_level,
  input wire logic        filter_sample_tick,
  input wire logic        tx_start,
  input wire logic        tx_stop,
  input wire logic        tx_bit_req,
  input wire logic        tx_busy,
  input wire logic [7:0]  synth_offset_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [7:0] hi_q;
  logic [2:0] mod_q;
  wire logic  wr = psel && penable && pwrite;
  wire logic  rd = psel && penable && !pwrite;

  // Shadows of sync high byte and modulation, followed from bus writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hi_q  <= RST_SYNC_HI;
      mod_q <= RST_SYNC_SETUP[6:4];
    end else if (wr && paddr == ADDR_SYNC_HI) begin
      hi_q  <= pwdata[7:0];
    end else if (wr && paddr == ADDR_SYNC_SETUP) begin
      mod_q <= pwdata[6:4];
    end
  end

  AST_SYNC_READBACK: assert property (
    rd && paddr == ADDR_SYNC_HI |-> prdata == {24'h0, hi_q})
    else $error("sync high byte reads wrong");
  AST_SYNTH_OFS: assert property (
    wr && paddr == ADDR_SYNTH_OFS |=> synth_offset_value == $past(pwdata[7:0]))
    else $error("synth offset not applied");
  AST_NO_TRACK_ASK: assert property (
    rd && paddr == ADDR_OFS_EST && (mod_q == MOD_ASK || mod_q == MOD_OOK)
    |-> prdata == 32'h0) else $error("estimate moves under amplitude keying");
  AST_BYTE_IN_SYNC: assert property (
    rx_byte_valid |-> $past(sync_found, 3)) else $error("byte without sync");
  AST_BYTE_PULSE: assert property (
    rx_byte_valid |=> !rx_byte_valid [*8]) else $error("bytes too close");
  AST_TICK_GAP: assert property (
    filter_sample_tick |=> !filter_sample_tick [*8])
    else $error("filter ticks too close");
  AST_TX_GO: assert property (
    tx_start && !tx_busy && !tx_stop |=> tx_busy) else $error("start lost");
  AST_TX_HALT: assert property (
    tx_stop && !tx_start |=> !tx_busy) else $error("stop lost");
  AST_SYNC_NO_REQ: assert property (
    $rose(tx_busy) |-> !tx_bit_req [*8]) else $error("data asked during sync");
  AST_REQ_SPACING: assert property (
    tx_bit_req |=> !tx_bit_req [*8]) else $error("bit requests too close");
  AST_RSSI_ON_TICK: assert property (
    $changed(rssi_level) |-> filter_sample_tick || $past(filter_sample_tick))
    else $error("level moved between ticks");

  // Main scenarios reached
  cover property ($rose(sync_found));
  cover property (tx_bit_req);
  cover property (rd && paddr == ADDR_OFS_EST && prdata != 32'h0);
endmodule : modem_rate_sync_asserts

bind modem_rate_sync modem_rate_sync_asserts u_modem_rate_sync_asserts (
  .clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .rx_byte_valid, .sync_found, .rssi_level, .filter_sample_tick,
  .tx_start, .tx_stop, .tx_bit_req, .tx_busy, .synth_offset_value);
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the modem rate and sync core
`timescale 1ns/1ps
`default_nettype none
module tb;
  import modem_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic        e;
  } row_t;
  typedef struct packed {
    logic [7:0]  s, p, q;
    logic        c;
    logic [31:0] w;
    logic [5:0]  n;
    logic        h;
  } rx_t;

  logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0, freq_error_in = 8'h64, amplitude_in = 8'h80;
  logic [7:0]  preamble_quality_indicator = '0, got_b = '0;
  logic [31:0] pwdata = '0, rd_q;
  logic        carrier_sense = 0, rx_restart = 0, tx_start = 0, tx_stop = 0;
  logic        tx_data_in = 0, go = 0, err_q;
  logic [63:0] pat = '0;
  logic [6:0]  nb = '0;
  wire logic [31:0] prdata;
  wire logic [7:0]  rx_byte, rssi_level, synth_offset_value;
  wire logic        pready, pslverr, rx_bit_in, rx_byte_valid, sync_found;
  wire logic        filter_sample_tick, tx_bit_req, tx_bit_out, tx_busy, mbusy;
  int               error_cnt = 0, checks_done = 0, got_n = 0, i, k, n;

  // Rate set to 32 clocks a symbol: exponent 15, mantissa 0
  row_t regs [22] = '{
    '{8'h00, 0, 32'h40, 0}, '{8'h04, 0, 32'h88, 0}, '{8'h08, 0, 32'h02, 0},
    '{8'h0c, 0, 32'h5a, 0}, '{8'h10, 0, 32'hc3, 0}, '{8'h14, 0, 32'h36, 0},
    '{8'h18, 0, 32'h00, 0}, '{8'h24, 0, 32'h00, 0}, '{8'h1c, 0, 32'h00, 0},
    '{8'h20, 0, 32'h00, 0}, '{8'h2c, 0, 32'h00, 1}, '{8'h2c, 1, 32'hff, 1},
    '{8'h1c, 1, 32'hff, 0}, '{8'h1c, 0, 32'h00, 0}, '{8'h0c, 1, 32'ha5, 0},
    '{8'h0c, 0, 32'ha5, 0}, '{8'h0c, 1, 32'h5a, 0}, '{8'h00, 1, 32'h00, 0},
    '{8'h04, 1, 32'h8f, 0}, '{8'h04, 0, 32'h8f, 0}, '{8'h18, 1, 32'h3c, 0},
    '{8'h18, 0, 32'h3c, 0}};
  rx_t rxc [9] = '{
    '{8'h02, 8'h00, 8'h00, 0, 32'h5ac3, 6'd16, 1},
    '{8'h02, 8'h00, 8'h00, 0, 32'h5ac2, 6'd16, 0},
    '{8'h01, 8'h00, 8'h00, 0, 32'h5ac2, 6'd16, 1},
    '{8'h03, 8'h00, 8'h00, 0, 32'h5ac35ad2, 6'd32, 1},
    '{8'h03, 8'h00, 8'h00, 0, 32'h5ac35ad0, 6'd32, 0},
    '{8'h06, 8'h00, 8'h00, 0, 32'h5ac3, 6'd16, 0},
    '{8'h06, 8'h00, 8'h00, 1, 32'h5ac3, 6'd16, 1},
    '{8'h02, 8'h8a, 8'h05, 0, 32'h5ac3, 6'd16, 0},
    '{8'h02, 8'h8a, 8'h14, 0, 32'h5ac3, 6'd16, 1}};

  always #2.5 clk = ~clk;

  modem_rate_sync u_modem_rate_sync (
    .clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .rx_bit_in, .freq_error_in, .amplitude_in,
    .carrier_sense, .preamble_quality_indicator, .rx_restart, .rx_byte,
    .rx_byte_valid, .sync_found, .rssi_level, .filter_sample_tick,
    .tx_start, .tx_stop, .tx_data_in, .tx_bit_req, .tx_bit_out, .tx_busy,
    .synth_offset_value);
  radio_tx_model u_radio_tx_model (
    .clk, .go, .pattern(pat), .nbits(nb), .busy(mbusy), .bit_out(rx_bit_in));

  // Keep the first byte after a hit; later ones are idle noise
  always @(posedge clk)
    if (rx_byte_valid === 1'b1) begin
      if (got_n == 0)
        got_b <= rx_byte;
      got_n <= got_n + 1;
    end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc

  // One bus transfer; answer taken at the edge that samples pready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin error_cnt++; stop_test(); end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb

  // Preamble, sync word of n bits, one data byte, then wait for the tail
  task automatic frame(input logic [31:0] sw, input int n, input logic [7:0] b);
    pat <= (((64'haaaa << n) | {32'h0, sw}) << 8) | {56'h0, b};
    nb <= 7'(24 + n);
    rx_restart <= 1;
    go <= 1;
    @(posedge clk);
    rx_restart <= 0;
    go <= 0;
    // A byte of the last frame may still land; clear the count after it
    @(posedge clk);
    @(negedge clk);
    got_n = 0;
    for (k = 0; k < 5000 && (mbusy || k < 64); k++) @(posedge clk);
    if (k == 5000) begin error_cnt++; stop_test(); end
    // Last bit is sampled mid-symbol, the byte two cycles later
    cyc(40);
  endtask : frame

  // Cycles between two filter ticks, sampled away from the edge
  task automatic gap(output int g);
    for (k = 0; k < 2000 && filter_sample_tick !== 1'b1; k++) @(negedge clk);
    g = 0;
    do begin @(negedge clk); g++; end
      while (filter_sample_tick !== 1'b1 && g < 2000);
    if (k == 2000 || g == 2000) begin error_cnt++; stop_test(); end
    @(posedge clk);
  endtask : gap

  initial begin
    cyc(10);
    sys_rst <= 0;
    cyc(1);
    foreach (regs[j]) begin
      apb(regs[j].a, regs[j].w, regs[j].d);
      chk(err_q, regs[j].e);
      if (!regs[j].w) chk(rd_q, regs[j].d);
    end
    chk(synth_offset_value, 8'h3c);
    // Offset tracking: frozen, clamped at 64 then 32, off for ASK
    cyc(640);
    apb(ADDR_OFS_EST, 0, 0); chk(rd_q, 32'h0);
    carrier_sense <= 1;
    cyc(2000);
    apb(ADDR_OFS_EST, 0, 0); chk(rd_q, 32'h40);
    apb(ADDR_OFS_CFG, 1, 32'h35);
    cyc(640);
    apb(ADDR_OFS_EST, 0, 0); chk(rd_q, 32'h20);
    apb(ADDR_SYNC_SETUP, 1, 32'h32);
    cyc(640);
    apb(ADDR_OFS_EST, 0, 0); chk(rd_q, 32'h0);
    for (i = 0; i < 2; i++) begin
      apb(ADDR_BW_RATE, 1, i ? 32'hdf : 32'h8f);
      gap(n);
      gap(n);
      chk(n, i ? 8 * 5 * 8 : 8 * 4 * 4);
    end
    foreach (rxc[j]) begin
      apb(ADDR_SYNC_SETUP, 1, {24'h0, rxc[j].s});
      apb(ADDR_PQI_CFG, 1, {24'h0, rxc[j].p});
      carrier_sense <= rxc[j].c;
      preamble_quality_indicator <= rxc[j].q;
      got_b = 8'h00;
      frame(rxc[j].w, 32'(rxc[j].n), 8'ha5);
      chk(sync_found, rxc[j].h);
      chk(got_b, rxc[j].h ? 8'ha5 : 8'h00);
    end
    // Level needs some forty filter ticks to settle within 16 of input
    chk(rssi_level >= 8'h71 && rssi_level <= 8'h80, 1);
    // Transmit: word sent twice, then payload; a second start is ignored
    apb(ADDR_SYNC_HI, 1, 32'ha5);
    apb(ADDR_SYNC_SETUP, 1, 32'h03);
    tx_start <= 1;
    @(posedge clk);
    tx_start <= 0;
    for (k = 0; k < 100 && tx_bit_out !== 1'b1; k++) @(posedge clk);
    if (k == 100) begin error_cnt++; stop_test(); end
    cyc(16);
    for (i = 0; i < 36; i++) begin
      chk(tx_bit_out, i < 32 ? 1'(32'ha5c3a5c3 >> (31 - i)) : i > 33);
      tx_start <= (i == 4);
      if (i == 33) tx_data_in <= 1;
      cyc(32);
    end
    tx_stop <= 1;
    cyc(2);
    chk(tx_busy, 0);
    tx_stop <= 0;
    // Reset in mid-run restores the documented values
    sys_rst <= 1;
    cyc(10);
    sys_rst <= 0;
    cyc(1);
    apb(ADDR_SYNC_HI, 0, 0); chk(rd_q, {24'h0, RST_SYNC_HI});
    chk(synth_offset_value, RST_SYNTH_OFS);
    stop_test();
  end
endmodule : tb
`default_nettype wire
